// ### common/rsp_pkg.sv
// shared constants of the rtc serial slave port and its bus master end
// assumes a 100 mhz core clock on both ends
package rsp_pkg;
  // ------------------------------------------------------------
  // bus addressing and register file
  // ------------------------------------------------------------
  localparam logic [6:0] DEV_ADDR      = 7'h68;
  localparam logic       DIR_WR        = 1'b0;
  localparam logic       DIR_RD        = 1'b1;
  localparam int         NUM_REGS      = 8;
  localparam int         PTR_W         = 3;
  localparam int         BYTE_W        = 8;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] LAST_BIT      = 4'h7;
  localparam logic [2:0] PTR_RST       = 3'h0;
  localparam logic [2:0] REG_SECONDS   = 3'h0;
  localparam logic [2:0] REG_MINUTES   = 3'h1;
  localparam logic [2:0] REG_HOURS     = 3'h2;
  localparam logic [2:0] REG_DAY       = 3'h3;
  localparam logic [2:0] REG_DATE      = 3'h4;
  localparam logic [2:0] REG_MONTH     = 3'h5;
  localparam logic [2:0] REG_YEARS     = 3'h6;
  localparam logic [2:0] REG_CONTROL   = 3'h7;
  localparam logic [7:0] REG_RST       = 8'h00;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int         CLK_FREQ_KHZ  = 100000;
  localparam int         SCL_FAST_KHZ  = 400;
  localparam int         SCL_STD_KHZ   = 100;
  // least quarter period, rounded up so the bus never exceeds its limit
  localparam int         QTR_CYC_I     = (CLK_FREQ_KHZ + 4 * SCL_FAST_KHZ - 1) / (4 * SCL_FAST_KHZ);
  localparam logic [6:0] QTR_CYC       = 7'(QTR_CYC_I);
  localparam int         FIFO_DEPTH    = 32;
endpackage : rsp_pkg

// ### common/rsp_if.sv
// two-wire open-drain bus between the master end and the slave end
// assumes both ends drive only low; the wire levels are resolved here
`timescale 1ns/1ns
interface rsp_if;
  logic mst_scl_out;
  logic mst_scl_oe_n;
  logic mst_sda_out;
  logic mst_sda_oe_n;
  logic dev_sda_out;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // pull-up wins unless an enabled driver shows low
  assign scl = ~(~mst_scl_oe_n & ~mst_scl_out);
  assign sda = ~((~mst_sda_oe_n & ~mst_sda_out) | (~dev_sda_oe_n & ~dev_sda_out));

  modport dev (
    input  scl,
    input  sda,
    output dev_sda_out,
    output dev_sda_oe_n
  );
  modport mst (
    input  scl,
    input  sda,
    output mst_scl_out,
    output mst_scl_oe_n,
    output mst_sda_out,
    output mst_sda_oe_n
  );
endinterface : rsp_if

// ### verilog/rsp_fifo.sv
// synchronous first-in first-out buffer with valid/ready on both sides
// assumes one clock; full refuses writes, empty shows no valid
`timescale 1ns/1ns
module rsp_fifo #(
  parameter int W = 8,
  parameter int D = 32
) (
  input  wire logic         clk_in,
  input  wire logic         rstn_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } rsp_fifo_s;

  rsp_fifo_s r;
  rsp_fifo_s n;
  logic      push;
  logic      pop;

  assign in_ready_out  = (r.cnt != (AW + 1)'(D));
  assign out_valid_out = (r.cnt != '0);
  assign out_data_out  = r.mem[r.rp];
  assign push          = in_valid_in & in_ready_out;
  assign pop           = out_valid_out & out_ready_in;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wp] = in_data_in;
      n.wp        = r.wp + 1'b1;
    end
    if (pop) begin
      n.rp = r.rp + 1'b1;
    end
    n.cnt = r.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : rsp_fifo

// ### verilog/rsp_dev.sv
// slave end of the rtc serial port: address match, pointer, eight bytes
// assumes a bus master makes every clock pulse; bus lines and the supply
// good level arrive asynchronously and are synchronised here
`timescale 1ns/1ns
// Summary of operation
// RULE_01: answer only own address after start
// RULE_02: eight bytes, seconds through control, in order
// RULE_03: supply low aborts transfer, clears pointer
// RULE_04: supply low ignores bus until restored
// RULE_05: master makes clock, start and stop
// RULE_06: new transfer only from idle bus
// RULE_07: data falling, clock high is start
// RULE_08: data rising, clock high is stop
// RULE_09: data changes only while clock low
// RULE_10: bytes msb first, ninth bit acknowledges
// RULE_11: acknowledge holds data low whole high
// RULE_12: master nack ends read, slave releases
// RULE_13: repeated start re-evaluates the address
// RULE_14: first byte: seven address, direction bit
// RULE_15: acknowledge a matching address byte
// RULE_16: first written byte loads the pointer
// RULE_17: further written bytes stored, pointer advances
// RULE_18: read starts at the current pointer
// RULE_19: read advances pointer until master nack
// RULE_20: bursts of any length are handled
// RULE_21: works up to fast bus rate
// RULE_22: pointer wraps from control to seconds
// RULE_23: bus lines synchronised, edges detected internally
module rsp_dev (
  input  wire logic        CLK_IN,
  input  wire logic        RSTN_IN,
  rsp_if.dev               BUS,
  input  wire logic        VCC_OK_IN,
  input  wire logic        UPD_VALID_IN,
  input  wire logic [2:0]  UPD_IDX_IN,
  input  wire logic [7:0]  UPD_DATA_IN,
  output logic             WR_STB_OUT,
  output logic [2:0]       WR_IDX_OUT,
  output logic [7:0]       WR_DATA_OUT,
  output logic [2:0]       PTR_OUT,
  output logic             BUSY_OUT,
  output logic [63:0]      REGS_OUT
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    S_IDLE  = 3'h0,
    S_ADDR  = 3'h1,
    S_PTR   = 3'h2,
    S_WDATA = 3'h3,
    S_ACK   = 3'h4,
    S_TX    = 3'h5,
    S_TXACK = 3'h6
  } rsp_dst_e;

  typedef struct packed {
    logic                            scl_m;
    logic                            scl_s;
    logic                            scl_d;
    logic                            sda_m;
    logic                            sda_s;
    logic                            sda_d;
    logic                            vok_m;
    logic                            vok_s;
    rsp_dst_e                        st;
    rsp_dst_e                        after;
    logic [3:0]                      bcnt;
    logic [7:0]                      sh;
    logic                            drv;
    logic                            acked;
    logic [2:0]                      ptr;
    logic [rsp_pkg::NUM_REGS-1:0][7:0] regs;
    logic                            wr_stb;
    logic [2:0]                      wr_idx;
    logic [7:0]                      wr_data;
  } rsp_dst_s;

  rsp_dst_s   r;
  rsp_dst_s   n;
  logic       rise;
  logic       fall;
  logic       start;
  logic       stop;
  logic [7:0] tx_byte;

  // pointer advance wraps through the eight locations
  function automatic logic [2:0] ptr_inc(input logic [2:0] p);
    ptr_inc = p + 3'h1; // RULE_22
  endfunction : ptr_inc

  // ------------------------------------------------------------
  // line events
  // ------------------------------------------------------------
  // only the second and third stages are looked at, so the first
  // stage may go metastable without harm; at 100 mhz a fast-rate
  // bit still spans some 250 samples
  assign rise    = r.scl_s & ~r.scl_d; // RULE_23 RULE_21
  assign fall    = ~r.scl_s & r.scl_d; // RULE_23
  assign start   = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s; // RULE_07
  assign stop    = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s; // RULE_08
  assign tx_byte = r.regs[r.ptr]; // RULE_18

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    n        = r;
    n.scl_m  = BUS.scl; // RULE_23
    n.scl_s  = r.scl_m;
    n.scl_d  = r.scl_s;
    n.sda_m  = BUS.sda;
    n.sda_s  = r.sda_m;
    n.sda_d  = r.sda_s;
    n.vok_m  = VCC_OK_IN;
    n.vok_s  = r.vok_m;
    n.wr_stb = 1'b0;
    // local update from the timekeeping side; a bus write in the same
    // cycle overrides it below
    if (UPD_VALID_IN) begin
      n.regs[UPD_IDX_IN] = UPD_DATA_IN;
    end
    if (!r.vok_s) begin
      n.st   = S_IDLE; // RULE_03 RULE_04
      n.drv  = 1'b0;
      n.bcnt = 4'h0;
      n.ptr  = rsp_pkg::PTR_RST; // RULE_03
    end else if (start) begin
      // also a repeated start: always back to address decode
      n.st   = S_ADDR; // RULE_13 RULE_06
      n.bcnt = 4'h0;
      n.drv  = 1'b0;
    end else if (stop) begin
      n.st  = S_IDLE; // RULE_08
      n.drv = 1'b0;
    end else begin
      case (r.st)
        S_ADDR, S_PTR, S_WDATA: begin
          if (rise) begin
            n.sh   = {r.sh[6:0], r.sda_s}; // RULE_10 RULE_09
            n.bcnt = r.bcnt + 4'h1;
          end
          if (fall && r.bcnt == rsp_pkg::BITS_PER_BYTE) begin
            n.bcnt = 4'h0;
            n.drv  = 1'b1; // RULE_11
            n.st   = S_ACK;
            if (r.st == S_ADDR) begin
              if (r.sh[7:1] == rsp_pkg::DEV_ADDR) begin // RULE_01 RULE_14
                n.after = (r.sh[0] == rsp_pkg::DIR_RD) ? S_TX : S_PTR; // RULE_14 RULE_15
              end else begin
                // not ours: stay off the bus until the next start
                n.drv = 1'b0; // RULE_01
                n.st  = S_IDLE;
              end
            end else if (r.st == S_PTR) begin
              // only the low bits select one of the eight bytes
              n.ptr   = r.sh[2:0]; // RULE_16
              n.after = S_WDATA;
            end else begin
              n.regs[r.ptr] = r.sh; // RULE_17 RULE_02
              n.wr_stb      = 1'b1;
              n.wr_idx      = r.ptr;
              n.wr_data     = r.sh;
              n.ptr         = ptr_inc(r.ptr); // RULE_17 RULE_20
              n.after       = S_WDATA;
            end
          end
        end
        S_ACK: begin
          if (fall) begin
            n.bcnt = 4'h0;
            if (r.after == S_TX) begin
              n.sh  = tx_byte; // RULE_18
              n.drv = ~tx_byte[7]; // RULE_10
              n.st  = S_TX;
            end else begin
              n.drv = 1'b0;
              n.st  = r.after;
            end
          end
        end
        S_TX: begin
          if (fall) begin
            if (r.bcnt == rsp_pkg::LAST_BIT) begin
              n.drv   = 1'b0; // RULE_12
              n.acked = 1'b0;
              n.st    = S_TXACK;
              n.ptr   = ptr_inc(r.ptr); // RULE_19 RULE_22
            end else begin
              n.sh   = {r.sh[6:0], 1'b0};
              n.drv  = ~r.sh[6]; // RULE_09
              n.bcnt = r.bcnt + 4'h1;
            end
          end
        end
        S_TXACK: begin
          if (rise) begin
            if (r.sda_s) begin
              // not acknowledged: keep the line released for the stop
              n.st = S_IDLE; // RULE_12
            end else begin
              n.acked = 1'b1; // RULE_19
            end
          end
          if (fall && r.acked) begin
            n.bcnt = 4'h0;
            n.sh   = tx_byte; // RULE_20
            n.drv  = ~tx_byte[7];
            n.st   = S_TX;
          end
        end
        default: begin
          n.drv = 1'b0;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      r       <= '0;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.scl_d <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
      r.sda_d <= 1'b1;
      r.st    <= S_IDLE;
      r.after <= S_IDLE;
      r.ptr   <= rsp_pkg::PTR_RST;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // the clock line is never driven from this end
  assign BUS.dev_sda_out  = 1'b0; // RULE_05
  assign BUS.dev_sda_oe_n = ~r.drv; // RULE_11
  assign WR_STB_OUT       = r.wr_stb;
  assign WR_IDX_OUT       = r.wr_idx;
  assign WR_DATA_OUT      = r.wr_data;
  assign PTR_OUT          = r.ptr;
  assign BUSY_OUT         = (r.st != S_IDLE);
  assign REGS_OUT         = r.regs;
endmodule : rsp_dev

// ### verilog/rsp_mst.sv
// master end: makes the bus clock by division, start, stop and bytes
// assumes the slave never stretches the clock; write data comes through
// a buffer and the bus clock is held low while it runs dry
`timescale 1ns/1ns
module rsp_mst (
  input  wire logic       CLK_IN,
  input  wire logic       RSTN_IN,
  rsp_if.mst              BUS,
  input  wire logic       CMD_VALID_IN,
  output logic            CMD_READY_OUT,
  input  wire logic       CMD_READ_IN,
  input  wire logic       CMD_SETPTR_IN,
  input  wire logic [7:0] CMD_PTR_IN,
  input  wire logic [7:0] CMD_LEN_IN,
  input  wire logic       TX_VALID_IN,
  output logic            TX_READY_OUT,
  input  wire logic [7:0] TX_DATA_IN,
  output logic            RX_VALID_OUT,
  output logic [7:0]      RX_DATA_OUT,
  output logic            DONE_OUT,
  output logic            NACK_OUT,
  output logic            BUSY_OUT
);
  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_START = 3'h1,
    H_BYTE  = 3'h2,
    H_WAIT  = 3'h3,
    H_STOP  = 3'h4
  } rsp_hst_e;
  typedef enum logic [1:0] {
    BK_ADDR = 2'h0,
    BK_PTR  = 2'h1,
    BK_DATA = 2'h2
  } rsp_bk_e;
  typedef struct packed {
    logic       scl_m;
    logic       scl_s;
    logic       sda_m;
    logic       sda_s;
    logic       scl_lo;
    logic       sda_lo;
    rsp_hst_e   st;
    rsp_bk_e    bk;
    logic [1:0] q;
    logic [6:0] tcnt;
    logic [3:0] bcnt;
    logic [7:0] sh;
    logic       rxm;
    logic       dir;
    logic       rd;
    logic [7:0] ptr;
    logic [7:0] left;
    logic       ackd;
    logic       rxv;
    logic [7:0] rxd;
    logic       done;
    logic       nack;
  } rsp_hst_s;

  rsp_hst_s   r;
  rsp_hst_s   n;
  logic       tick;
  logic [1:0] nq;
  logic       bus_idle;
  logic       f_valid;
  logic [7:0] f_data;

  // ------------------------------------------------------------
  // write data buffer
  // ------------------------------------------------------------
  rsp_fifo #(
    .W (rsp_pkg::BYTE_W),
    .D (rsp_pkg::FIFO_DEPTH)
  ) u_txq (
    .clk_in        (CLK_IN),
    .rstn_in       (RSTN_IN),
    .in_valid_in   (TX_VALID_IN),
    .in_ready_out  (TX_READY_OUT),
    .in_data_in    (TX_DATA_IN),
    .out_valid_out (f_valid),
    .out_ready_in  (r.st == H_WAIT),
    .out_data_out  (f_data)
  );

  assign tick          = (r.tcnt == rsp_pkg::QTR_CYC - 7'h1);
  assign nq            = r.q + 2'h1;
  assign bus_idle      = r.scl_s & r.sda_s; // RULE_06
  assign CMD_READY_OUT = (r.st == H_IDLE) & bus_idle; // RULE_06

  // ------------------------------------------------------------
  // sequencer, one quarter of a bit per tick
  // ------------------------------------------------------------
  always_comb begin
    n       = r;
    n.scl_m = BUS.scl;
    n.scl_s = r.scl_m;
    n.sda_m = BUS.sda;
    n.sda_s = r.sda_m;
    n.rxv   = 1'b0;
    n.done  = 1'b0;
    n.tcnt  = tick ? 7'h0 : r.tcnt + 7'h1;
    if (tick) begin
      n.q = nq;
    end
    case (r.st)
      H_IDLE: begin
        if (CMD_VALID_IN && CMD_READY_OUT) begin
          n.rd   = CMD_READ_IN & CMD_SETPTR_IN;
          n.dir  = CMD_READ_IN & ~CMD_SETPTR_IN;
          n.ptr  = CMD_PTR_IN;
          n.left = (CMD_READ_IN && CMD_LEN_IN == 8'h0) ? 8'h1 : CMD_LEN_IN;
          n.nack = 1'b0;
          n.st   = H_START;
          n.q    = 2'h3;
          n.tcnt = 7'h0;
        end
      end
      H_START: begin
        if (tick) begin
          case (nq)
            2'h0: begin
              n.scl_lo = 1'b1; // RULE_05
              n.sda_lo = 1'b0;
            end
            2'h1: n.scl_lo = 1'b0;
            2'h2: n.sda_lo = 1'b1; // RULE_07 RULE_13
            default: begin
              n.scl_lo = 1'b1;
              n.st     = H_BYTE;
              n.bk     = BK_ADDR;
              n.bcnt   = 4'h0;
              n.rxm    = 1'b0;
              n.sh     = {rsp_pkg::DEV_ADDR, r.dir};
            end
          endcase
        end
      end
      H_BYTE: begin
        if (tick) begin
          case (nq)
            2'h0: begin
              // data changes only with the clock held low
              n.scl_lo = 1'b1; // RULE_09
              if (r.bcnt != rsp_pkg::BITS_PER_BYTE) begin
                n.sda_lo = ~r.rxm & ~r.sh[7]; // RULE_10
              end else begin
                n.sda_lo = r.rxm & (r.left != 8'h1); // RULE_12 RULE_11
              end
            end
            2'h1: n.scl_lo = 1'b0;
            2'h2: begin
              if (r.bcnt != rsp_pkg::BITS_PER_BYTE && r.rxm) begin
                n.sh = {r.sh[6:0], r.sda_s};
              end
              if (r.bcnt == rsp_pkg::BITS_PER_BYTE) begin
                n.ackd = ~r.sda_s;
              end
            end
            default: begin
              n.scl_lo = 1'b1;
              if (r.bcnt != rsp_pkg::BITS_PER_BYTE) begin
                n.bcnt = r.bcnt + 4'h1;
                if (!r.rxm) begin
                  n.sh = {r.sh[6:0], 1'b0};
                end
              end else begin
                n.bcnt = 4'h0;
                if (!r.rxm && !r.ackd) begin
                  n.nack = 1'b1;
                  n.st   = H_STOP;
                end else if (r.bk == BK_ADDR) begin
                  n.bk  = r.dir ? BK_DATA : BK_PTR;
                  n.rxm = r.dir;
                  n.sh  = r.ptr;
                end else if (r.bk == BK_PTR) begin
                  if (r.rd) begin
                    n.dir = rsp_pkg::DIR_RD; // RULE_13
                    n.st  = H_START;
                  end else begin
                    n.st = (r.left == 8'h0) ? H_STOP : H_WAIT;
                  end
                end else begin
                  n.left = r.left - 8'h1; // RULE_20
                  n.rxv  = r.rxm;
                  n.rxd  = r.sh;
                  if (r.left == 8'h1) begin
                    n.st = H_STOP;
                  end else if (!r.rxm) begin
                    n.st = H_WAIT;
                  end
                end
              end
            end
          endcase
        end
      end
      H_WAIT: begin
        // clock stays low until the buffer has a byte
        if (f_valid) begin
          n.sh   = f_data;
          n.bk   = BK_DATA;
          n.rxm  = 1'b0;
          n.st   = H_BYTE;
          n.q    = 2'h3;
          n.tcnt = 7'h0;
        end
      end
      H_STOP: begin
        if (tick) begin
          case (nq)
            2'h0: begin
              n.scl_lo = 1'b1;
              n.sda_lo = 1'b1;
            end
            2'h1: n.scl_lo = 1'b0;
            2'h2: n.sda_lo = 1'b0; // RULE_08
            default: begin
              n.st   = H_IDLE;
              n.done = 1'b1;
            end
          endcase
        end
      end
      default: n.st = H_IDLE;
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      r       <= '0;
      r.st    <= H_IDLE;
      r.bk    <= BK_ADDR;
      r.scl_m <= 1'b1;
      r.scl_s <= 1'b1;
      r.sda_m <= 1'b1;
      r.sda_s <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign BUS.mst_scl_out  = 1'b0;
  assign BUS.mst_scl_oe_n = ~r.scl_lo; // RULE_05
  assign BUS.mst_sda_out  = 1'b0;
  assign BUS.mst_sda_oe_n = ~r.sda_lo;
  assign RX_VALID_OUT     = r.rxv;
  assign RX_DATA_OUT      = r.rxd;
  assign DONE_OUT         = r.done;
  assign NACK_OUT         = r.nack;
  assign BUSY_OUT         = (r.st != H_IDLE);
endmodule : rsp_mst

// ### testbench/rsp_chk.sv
// link checker: framing and timing of the two-wire bus
// assumes one core clock and one reset shared by both ends
`timescale 1ns/1ns
module rsp_chk (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic mst_scl_out,
  input wire logic mst_scl_oe_n,
  input wire logic dev_sda_out,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  logic       dpull;
  logic       scl_q;
  logic       sda_q;
  logic [3:0] bc_r;
  logic [7:0] hi_r;
  logic [7:0] per_r;
  assign dpull = ~dev_sda_oe_n & ~dev_sda_out;
  // the span counters saturate so idle or stalled spans never wrap round; the bit count wraps from 8 to 0
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      bc_r  <= 4'h0;
      hi_r  <= 8'hff;
      per_r <= 8'hff;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
      hi_r  <= !scl ? 8'h00 : (hi_r == 8'hff ? hi_r : hi_r + 8'h01);
      per_r <= (scl && !scl_q) ? 8'h01 : (per_r == 8'hff ? per_r : per_r + 8'h01);
      // start and stop both re-arm the count; their own set-up pulse then makes it one
      if (scl && scl_q && (sda != sda_q)) bc_r <= 4'h0;
      else if (scl && !scl_q) bc_r <= (bc_r == 4'h8) ? 4'h0 : bc_r + 4'h1;
    end
  end
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  a_scl_pull_only: assert property (!mst_scl_oe_n |-> !mst_scl_out)
    else $error("clock line driven high");
  a_dev_sda_still: assert property (scl && $past(scl) |-> $stable(dpull))
    else $error("slave moved data while clock high");
  a_start_hold: assert property ($fell(sda) && scl |-> scl [*8])
    else $error("clock fell right after start");
  a_stop_free: assert property ($rose(sda) && scl |-> sda [*8])
    else $error("bus not free after stop");
  a_byte_frame: assert property (scl && $past(scl) && $changed(sda) |-> bc_r == 4'h1)
    else $error("start or stop inside a byte");
  a_ack_low_high: assert property ($rose(scl) && dpull |-> !sda [*8])
    else $error("pulled data not low through clock high");
  a_scl_high_min: assert property ($fell(scl) |-> hi_r >= 8'd60)
    else $error("clock high too short");
  a_scl_period: assert property ($rose(scl) |-> per_r >= 8'd248)
    else $error("clock faster than fast mode");
endmodule : rsp_chk

// ### testbench/rtc_serial_slave_access_port_test.sv
// bench: master end drives the slave end over the shared interface
// assumes the checker beside the interface and the 100 mhz core clock
`timescale 1ns/1ns
module rtc_serial_slave_access_port_test;
  logic        clk, rstn, vcc, cv, crd, csp, tv, uv, crdy, trdy, rxv, done, nack, wst, dbsy, mbsy;
  logic [7:0]  cp, cl, td, ud, rxd, wdt;
  logic [2:0]  ui, ptr, eptr, wix;
  logic [63:0] regs;
  logic [7:0]  exp_r [8];
  logic [7:0]  txq [$];
  logic [7:0]  rxq [$];
  int          n_errors, checked, n_done, n_wst;
  rsp_if bus ();
  rsp_dev rsp_dev_i (.CLK_IN(clk), .RSTN_IN(rstn), .BUS(bus.dev), .VCC_OK_IN(vcc), .UPD_VALID_IN(uv),
    .UPD_IDX_IN(ui), .UPD_DATA_IN(ud), .WR_STB_OUT(wst), .WR_IDX_OUT(wix), .WR_DATA_OUT(wdt), .PTR_OUT(ptr),
    .BUSY_OUT(dbsy), .REGS_OUT(regs));
  rsp_mst rsp_mst_i (.CLK_IN(clk), .RSTN_IN(rstn), .BUS(bus.mst), .CMD_VALID_IN(cv), .CMD_READY_OUT(crdy),
    .CMD_READ_IN(crd), .CMD_SETPTR_IN(csp), .CMD_PTR_IN(cp), .CMD_LEN_IN(cl), .TX_VALID_IN(tv),
    .TX_READY_OUT(trdy), .TX_DATA_IN(td), .RX_VALID_OUT(rxv), .RX_DATA_OUT(rxd), .DONE_OUT(done),
    .NACK_OUT(nack), .BUSY_OUT(mbsy));
  rsp_chk rsp_chk_i (.clk_in(clk), .rstn_in(rstn), .mst_scl_out(bus.mst_scl_out),
    .mst_scl_oe_n(bus.mst_scl_oe_n), .dev_sda_out(bus.dev_sda_out), .dev_sda_oe_n(bus.dev_sda_oe_n),
    .scl(bus.scl), .sda(bus.sda));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // pulses are looked at mid-cycle, where they have settled
  always @(negedge clk) begin
    if (done === 1'b1) n_done++;
    if (rxv === 1'b1) rxq.push_back(rxd);
    if (wst === 1'b1) n_wst++;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [63:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic summarize();
    if (n_errors == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task automatic cmd(input logic r, s, input logic [7:0] p, l);
    int d;
    d = n_done;
    @(negedge clk);
    {cv, crd, csp, cp, cl} = {1'b1, r, s, p, l};
    while (crdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    cv = 1'b0;
    repeat (40000) if (n_done == d) @(negedge clk);
    chk("done", n_done, d + 1);
  endtask : cmd
  task automatic push(input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      {tv, td} = {1'b1, 8'($urandom)};
      while (trdy !== 1'b1) @(negedge clk);
      txq.push_back(td);
    end
    @(negedge clk);
    tv = 1'b0;
  endtask : push
  task automatic regs_ok();
    for (int i = 0; i < 8; i++) chk("reg", regs[8*i+:8], exp_r[i]);
    chk("ptr", ptr, eptr);
    chk("nack", nack, 1'b0);
    chk("busy", {dbsy, mbsy}, 2'b00);
  endtask : regs_ok
  // late bytes arrive while the master stalls on an empty buffer
  task automatic wr(input logic [7:0] p, input int n, late);
    int w;
    w = n_wst;
    fork
      cmd(1'b0, 1'b0, p, 8'(n));
      if (late > 0) begin
        repeat (6000) @(negedge clk);
        push(late);
      end
    join
    chk("wr_stb", n_wst - w, n);
    eptr = p[2:0];
    repeat (n) begin
      exp_r[eptr] = txq.pop_front();
      eptr++;
    end
    if (n > 0) chk("wr_last", {wix, wdt}, {eptr - 3'h1, exp_r[eptr - 3'h1]});
    regs_ok();
  endtask : wr
  task automatic rd(input logic s, input logic [7:0] p, input int n);
    rxq.delete();
    cmd(1'b1, s, p, 8'(n));
    if (s) eptr = p[2:0];
    chk("rx_count", rxq.size(), n);
    foreach (rxq[i]) begin
      chk("rx_data", rxq[i], exp_r[eptr]);
      eptr++;
    end
    regs_ok();
  endtask : rd
  initial begin
    {cv, crd, csp, tv, uv, cp, cl, td, ud, ui} = '0;
    rstn = 1'b0;
    vcc = 1'b1;
    void'($urandom(96971));
    foreach (exp_r[i]) exp_r[i] = rsp_pkg::REG_RST;
    eptr = rsp_pkg::PTR_RST;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    regs_ok();
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {uv, ui, ud} = {1'b1, 3'(i), 8'($urandom)};
      exp_r[i] = ud;
    end
    @(negedge clk);
    uv = 1'b0;
    rd(1'b0, 8'h00, 2);
    push(32);
    chk("tx_full", trdy, 1'b0);
    // bytes left in the buffer are dropped by the mid-run reset below
    wr(8'($urandom), 10, 0);
    rd(1'b1, 8'($urandom), 5);
    wr(8'($urandom), 5, 0);
    // nonzero low bits, so the supply drop has a pointer to clear
    wr(8'h0d, 0, 0);
    @(negedge clk);
    vcc = 1'b0;
    repeat (5) @(negedge clk);
    eptr = rsp_pkg::PTR_RST;
    chk("ptr_drop", ptr, eptr);
    cmd(1'b1, 1'b0, 8'h00, 8'h01);
    chk("nack_low", nack, 1'b1);
    vcc = 1'b1;
    repeat (5) @(negedge clk);
    rd(1'b0, 8'h00, 1);
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    txq.delete();
    foreach (exp_r[i]) exp_r[i] = rsp_pkg::REG_RST;
    eptr = rsp_pkg::PTR_RST;
    regs_ok();
    // empty buffer: the master must stall with the clock held low
    wr(8'($urandom), 2, 2);
    summarize();
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_errors++;
    summarize();
  end
endmodule : rtc_serial_slave_access_port_test
